// File: design/mtw_walker.v
// Function
// - upper kind 0/1 means table absent
// - no translation gives access error on retry
// - invalid descriptor left untouched; only kind examined
// - upper write protect applies to all below
// - plain walk accesses write-through, no allocate
// - locked walk accesses noncachable, push line
// - lock asserted only for read-modify-write
// - set clear used flag of each descriptor
// - set modified only without protect or violation
// - flag updates finish before page access
// - table descriptor written only if used clear
// - read: locked update if used clear
// - unprotected write update by used/modified
// - protected write never sets modified
// - alternate space alternate_space_move bypass translation
// - function code 6 to 5, 2 to 1
// - fault frame records converted function code
// - transfer type 10 or 00 by code
// - upper kinds 00/01 absent, 10/11 resident; page kinds 00/10 absent
// - invalid descriptor makes nonresident cache entry
// - modified flag never cleared
//
// table walk engine with descriptor flag maintenance
// assumes a simple memory port: req, we, addr, data, ack
`timescale 1ns/1ps
`include "mtw_defines.vh"
module mtw_walker #(
    parameter LEVELS = `MTW_LEVELS
) (
    input wire core_clk,
    input wire arst_n,
    input wire clk_en,
    // walk request from the translation miss path
    input wire walk_req,
    input wire [31:0] walk_laddr,
    input wire walk_write,
    input wire walk_super,
    input wire [31:0] root_ptr,
    // alternate space move request
    input wire alt_space_move,
    input wire [2:0] alt_fc,
    input wire [31:0] alt_addr,
    // retry of the original access
    input wire retry,
    // memory port
    output reg mem_req_r,
    output reg mem_we_r,
    output reg [31:0] mem_addr_r,
    output reg [31:0] mem_wdata_r,
    output reg mem_lock_r,
    output reg [1:0] mem_cache_mode_r,
    output reg mem_push_inv_r,
    input wire mem_ack,
    input wire mem_berr,
    input wire [31:0] mem_rdata,
    // translation cache entry write
    output reg tc_wr_r,
    output reg [31:0] tc_laddr_r,
    output reg [31:0] tc_paddr_r,
    output reg tc_resident_r,
    output reg tc_wp_r,
    output reg tc_sup_r,
    output reg tc_mod_r,
    output reg walk_done_r,
    output reg access_err_r,
    // alternate space results
    output reg [31:0] phys_addr_r,
    output reg phys_valid_r,
    output reg [2:0] transfer_modifier_field_r,
    output reg [1:0] transfer_type_r
);
    // -----------------------------------------
    // states
    // -----------------------------------------
    localparam S_IDLE = 3'h0;
    localparam S_FETCH = 3'h1;
    localparam S_EVAL = 3'h2;
    localparam S_LRD = 3'h3;
    localparam S_WR = 3'h4;
    localparam S_DONE = 3'h5;
    localparam S_ALT = 3'h6;

    reg [2:0] state_r; // walk state
    reg [1:0] lvl_r; // current level, 0 is root
    reg [31:0] desc_r; // last fetched descriptor
    reg wp_acc_r; // accumulated write protect
    reg resident_r; // walk found a translation
    reg err_pend_r; // error waits for the retry
    reg locked_r; // current update uses lock
    reg [31:0] laddr_r;
    reg write_r;
    reg super_r;

    // -----------------------------------------
    // descriptor decode
    // -----------------------------------------
    wire last_lvl = (lvl_r == LEVELS - 1);
    wire [1:0] pkind = desc_r[`MTW_PDK_LSB +: 2];
    // only the kind field is examined for an invalid entry
    wire up_absent = !desc_r[`MTW_UDK_LSB + `MTW_UDK_RES_BIT];
    wire pg_absent = (pkind == `MTW_PDK_INVALID) || (pkind == `MTW_PDK_INDIRECT);
    wire absent = last_lvl ? pg_absent : up_absent;
    wire wp_path = wp_acc_r | desc_r[`MTW_WP_BIT];
    wire sup_v = last_lvl && desc_r[`MTW_SUP_BIT] && !super_r;
    // index slice per level: 7, 7, then 6 bits
    wire [6:0] idx = (lvl_r == 2'h0) ? laddr_r[31:25] :
        (lvl_r == 2'h1) ? laddr_r[24:18] : {1'b0, laddr_r[17:12]};
    wire [31:0] next_addr = {desc_r[31:`MTW_BASE_LSB], idx, 2'h0};

    wire upd_need;
    wire upd_lock;
    wire [31:0] upd_desc;
    mtw_desc_flags u_flags (
        .desc(desc_r),
        .is_page(last_lvl),
        .is_write(write_r),
        .wp_acc(wp_path),
        .sup_viol(sup_v),
        .need_upd(upd_need),
        .need_lock(upd_lock),
        .new_desc(upd_desc)
    );

    wire [2:0] fc_conv;
    wire [1:0] tt_conv;
    mtw_fc_convert u_fc (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .alt_fc(alt_fc),
        .fc_conv_r(fc_conv),
        .tt_r(tt_conv)
    );

    // -----------------------------------------
    // walk sequencer
    // -----------------------------------------
    // every output is registered here; a locked update holds the lock
    // from its read through the write so the arbiter cannot slip in
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= S_IDLE;
            lvl_r <= 2'h0;
            desc_r <= 32'h0;
            wp_acc_r <= 1'b0;
            resident_r <= 1'b0;
            err_pend_r <= 1'b0;
            locked_r <= 1'b0;
            laddr_r <= 32'h0;
            write_r <= 1'b0;
            super_r <= 1'b0;
            mem_req_r <= 1'b0;
            mem_we_r <= 1'b0;
            mem_addr_r <= 32'h0;
            mem_wdata_r <= 32'h0;
            mem_lock_r <= 1'b0;
            mem_cache_mode_r <= 2'h0;
            mem_push_inv_r <= 1'b0;
            tc_wr_r <= 1'b0;
            tc_laddr_r <= 32'h0;
            tc_paddr_r <= 32'h0;
            tc_resident_r <= 1'b0;
            tc_wp_r <= 1'b0;
            tc_sup_r <= 1'b0;
            tc_mod_r <= 1'b0;
            walk_done_r <= 1'b0;
            access_err_r <= 1'b0;
            phys_addr_r <= 32'h0;
            phys_valid_r <= 1'b0;
            transfer_modifier_field_r <= 3'h0;
            transfer_type_r <= 2'h0;
        end else if (clk_en) begin
            // pulses default low
            tc_wr_r <= 1'b0;
            walk_done_r <= 1'b0;
            access_err_r <= 1'b0;
            phys_valid_r <= 1'b0;
            mem_push_inv_r <= 1'b0;
            // pending error is raised when the access is retried
            if (retry && err_pend_r) begin
                access_err_r <= 1'b1;
                err_pend_r <= 1'b0;
            end
            case (state_r)
                S_IDLE: begin
                    if (alt_space_move) begin
                        // no walk: the address is already physical
                        phys_addr_r <= alt_addr;
                        state_r <= S_ALT;
                    end else if (walk_req) begin
                        laddr_r <= walk_laddr;
                        write_r <= walk_write;
                        super_r <= walk_super;
                        wp_acc_r <= 1'b0;
                        lvl_r <= 2'h0;
                        mem_req_r <= 1'b1;
                        mem_we_r <= 1'b0;
                        mem_lock_r <= 1'b0;
                        mem_cache_mode_r <= `MTW_CM_WT_NOALLOC;
                        mem_addr_r <= {root_ptr[31:`MTW_BASE_LSB], walk_laddr[31:25], 2'h0};
                        state_r <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    if (mem_ack || mem_berr) begin
                        mem_req_r <= 1'b0;
                        desc_r <= mem_rdata;
                        if (mem_berr) begin
                            resident_r <= 1'b0;
                            state_r <= S_DONE;
                        end else begin
                            state_r <= S_EVAL;
                        end
                    end
                end
                S_EVAL: begin
                    if (absent) begin
                        // nonresident entry, descriptor not rewritten
                        resident_r <= 1'b0;
                        state_r <= S_DONE;
                    end else begin
                        wp_acc_r <= wp_path;
                        resident_r <= 1'b1;
                        if (upd_need && upd_lock) begin
                            // repeat the read under lock, line pushed
                            mem_req_r <= 1'b1;
                            mem_we_r <= 1'b0;
                            mem_lock_r <= 1'b1;
                            mem_cache_mode_r <= `MTW_CM_NONCACHE_PUSH;
                            mem_push_inv_r <= 1'b1;
                            locked_r <= 1'b1;
                            state_r <= S_LRD;
                        end else if (upd_need) begin
                            // plain write cycle, no lock
                            mem_req_r <= 1'b1;
                            mem_we_r <= 1'b1;
                            mem_wdata_r <= upd_desc;
                            locked_r <= 1'b0;
                            state_r <= S_WR;
                        end else if (last_lvl) begin
                            state_r <= S_DONE;
                        end else begin
                            lvl_r <= lvl_r + 2'h1;
                            mem_req_r <= 1'b1;
                            mem_addr_r <= next_addr;
                            state_r <= S_FETCH;
                        end
                    end
                end
                S_LRD: begin
                    if (mem_ack) begin
                        // write follows at once with lock still held
                        desc_r <= mem_rdata;
                        mem_we_r <= 1'b1;
                        mem_wdata_r <= mem_rdata | (upd_desc & ~desc_r);
                        state_r <= S_WR;
                    end
                end
                S_WR: begin
                    if (mem_ack || mem_berr) begin
                        mem_req_r <= 1'b0;
                        mem_we_r <= 1'b0;
                        mem_lock_r <= 1'b0;
                        mem_cache_mode_r <= `MTW_CM_WT_NOALLOC;
                        locked_r <= 1'b0;
                        desc_r <= mem_wdata_r;
                        // page only released after its update is in memory
                        if (last_lvl || mem_berr) begin
                            resident_r <= !mem_berr;
                            state_r <= S_DONE;
                        end else begin
                            lvl_r <= lvl_r + 2'h1;
                            mem_req_r <= 1'b1;
                            mem_addr_r <= next_addr;
                            state_r <= S_FETCH;
                        end
                    end
                end
                S_DONE: begin
                    // load the translation cache entry
                    tc_wr_r <= 1'b1;
                    tc_laddr_r <= laddr_r;
                    tc_paddr_r <= {desc_r[31:12], laddr_r[11:0]};
                    tc_resident_r <= resident_r;
                    tc_wp_r <= wp_acc_r;
                    tc_sup_r <= desc_r[`MTW_SUP_BIT];
                    tc_mod_r <= desc_r[`MTW_MOD_BIT];
                    walk_done_r <= 1'b1;
                    err_pend_r <= !resident_r;
                    state_r <= S_IDLE;
                end
                S_ALT: begin
                    // converted code goes to the fault frame field
                    transfer_modifier_field_r <= fc_conv;
                    transfer_type_r <= tt_conv;
                    phys_valid_r <= 1'b1;
                    state_r <= S_IDLE;
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// File: pkg/mtw_defines.vh
// constants for the table walk status update block
// assumes inclusion by bare name from design files
`ifndef MTW_DEFINES_VH
`define MTW_DEFINES_VH
// upper descriptor kind field position and resident bit
`define MTW_UDK_LSB 0
`define MTW_UDK_RES_BIT 1
// page descriptor kind field
`define MTW_PDK_LSB 0
`define MTW_PDK_INVALID 2'h0
`define MTW_PDK_INDIRECT 2'h2
// flag bit positions in a descriptor
`define MTW_WP_BIT 2
`define MTW_USED_BIT 3
`define MTW_MOD_BIT 4
`define MTW_SUP_BIT 7
// address bits of table/page base
`define MTW_BASE_LSB 9
`define MTW_IDX_SHIFT 2
// transfer type results
`define MTW_TT_NORMAL 2'h0
`define MTW_TT_ALT 2'h2
// function codes that are rewritten, and the data codes they become
`define MTW_FC_UPROG 3'h2
`define MTW_FC_UDATA 3'h1
`define MTW_FC_SPROG 3'h6
`define MTW_FC_SDATA 3'h5
// cache treatment of walk accesses
`define MTW_CM_WT_NOALLOC 2'h0
`define MTW_CM_NONCACHE_PUSH 2'h3
`define MTW_LEVELS 3
`endif

// File: design/mtw_fc_convert.v
// alternate space function code conversion
// assumes synchronous inputs on core_clk
`timescale 1ns/1ps
`include "mtw_defines.vh"
module mtw_fc_convert (
    input wire core_clk,
    input wire arst_n,
    input wire clk_en,
    input wire [2:0] alt_fc,
    output reg [2:0] fc_conv_r,
    output reg [1:0] tt_r
);
    // -----------------------------------------
    // code rewrite and transfer type
    // -----------------------------------------
    reg [2:0] fc_nxt;
    reg [1:0] tt_nxt;
    // instruction spaces fold onto data spaces
    always @* begin
        fc_nxt = alt_fc;
        if (alt_fc == `MTW_FC_SPROG) begin
            fc_nxt = `MTW_FC_SDATA;
        end else if (alt_fc == `MTW_FC_UPROG) begin
            fc_nxt = `MTW_FC_UDATA;
        end
        // codes with equal low bits give the alternate type
        tt_nxt = (alt_fc[0] == alt_fc[1]) ? `MTW_TT_ALT : `MTW_TT_NORMAL;
    end
    // registered so outputs come from flops
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fc_conv_r <= 3'h0;
            tt_r <= 2'h0;
        end else if (clk_en) begin
            fc_conv_r <= fc_nxt;
            tt_r <= tt_nxt;
        end
    end
endmodule

// File: design/mtw_desc_flags.v
// decides the flag update for one fetched descriptor
// assumes the descriptor word is stable while eval is high
`timescale 1ns/1ps
`include "mtw_defines.vh"
module mtw_desc_flags (
    input wire [31:0] desc,
    input wire is_page,
    input wire is_write,
    input wire wp_acc,
    input wire sup_viol,
    output reg need_upd,
    output reg need_lock,
    output reg [31:0] new_desc
);
    // -----------------------------------------
    // update decision
    // -----------------------------------------
    reg used;
    reg modf;
    always @* begin
        used = desc[`MTW_USED_BIT];
        modf = desc[`MTW_MOD_BIT];
        need_upd = 1'b0;
        need_lock = 1'b0;
        new_desc = desc;
        new_desc[`MTW_USED_BIT] = 1'b1;
        if (!is_page) begin
            // table descriptor, plain write only when used clear
            need_upd = !used;
        end else if (!is_write || wp_acc || sup_viol) begin
            // read, or write that is protected: set used only
            need_upd = !used;
            need_lock = !used;
        end else begin
            // unprotected write; modified only set, never cleared
            new_desc[`MTW_MOD_BIT] = 1'b1;
            need_upd = !(used && modf);
            need_lock = !used && modf;
        end
    end
endmodule

// File: testbench/mtw_walk_chk.sv
// port checker for the table walk engine
// assumes one clock domain, bound onto every mtw_walker
`timescale 1ns/1ps
`include "mtw_defines.vh"
module mtw_walk_chk (
    input wire core_clk,
    input wire arst_n,
    input wire alt_space_move,
    input wire [2:0] alt_fc,
    input wire [31:0] alt_addr,
    input wire retry,
    input wire mem_req_r,
    input wire mem_we_r,
    input wire [31:0] mem_wdata_r,
    input wire mem_lock_r,
    input wire [1:0] mem_cache_mode_r,
    input wire mem_push_inv_r,
    input wire mem_ack,
    input wire [31:0] mem_rdata,
    input wire tc_resident_r,
    input wire walk_done_r,
    input wire access_err_r,
    input wire [31:0] phys_addr_r,
    input wire phys_valid_r,
    input wire [2:0] transfer_modifier_field_r,
    input wire [1:0] transfer_type_r
);
    // ---------------------------------------------
    // helper: word seen by the locked read
    // ---------------------------------------------
    reg [31:0] lock_rd_r; // the locked write must echo this word with the used bit set
    wire lock_rd_ack; // locked read completes
    assign lock_rd_ack = mem_req_r && mem_lock_r && !mem_we_r && mem_ack;
    // capture on the read acknowledge only
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_rd_r <= 32'h0;
        end else if (lock_rd_ack) begin
            lock_rd_r <= mem_rdata;
        end
    end
    // expected code after instruction space folding
    function [2:0] fold_fc(input [2:0] f);
        fold_fc = (f == 3'h6) ? 3'h5 : ((f == 3'h2) ? 3'h1 : f);
    endfunction
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    plain_wt_a:
        assert property (mem_req_r && !mem_lock_r |-> mem_cache_mode_r == `MTW_CM_WT_NOALLOC)
        else $error("plain walk access not write-through");
    lock_nc_a:
        assert property (mem_req_r && mem_lock_r |-> mem_cache_mode_r == `MTW_CM_NONCACHE_PUSH)
        else $error("locked access cachable");
    push_lock_a:
        assert property (mem_push_inv_r |-> mem_lock_r && !mem_we_r ##1 !mem_push_inv_r)
        else $error("push pulse outside locked read");
    lock_start_a:
        assert property ($rose(mem_lock_r) |-> mem_req_r && !mem_we_r)
        else $error("lock not opened by a read");
    lock_pair_a:
        assert property (lock_rd_ack |=> mem_req_r && mem_we_r && mem_lock_r)
        else $error("locked read not followed by write");
    lock_end_a:
        assert property (mem_lock_r && mem_we_r && mem_ack |=> !mem_lock_r)
        else $error("lock held after write");
    lock_data_a:
        assert property (mem_req_r && mem_lock_r && mem_we_r |-> mem_wdata_r == (lock_rd_r | 32'h8))
        else $error("locked write data wrong");
    used_set_a:
        assert property (mem_req_r && mem_we_r |-> mem_wdata_r[3])
        else $error("descriptor write without used flag");
    alt_res_a:
        assert property (phys_valid_r |-> $past(alt_space_move, 2) &&
            phys_addr_r == $past(alt_addr, 2) &&
            transfer_modifier_field_r == fold_fc($past(alt_fc, 2)) &&
            transfer_type_r == (($past(alt_fc[1], 2) == $past(alt_fc[0], 2)) ? 2'h2 : 2'h0))
        else $error("alternate space result wrong");
    err_retry_a:
        assert property (access_err_r |-> $past(retry) && !tc_resident_r)
        else $error("access error without retry");
    done_free_a:
        assert property (walk_done_r |-> !mem_req_r && !mem_lock_r)
        else $error("walk done with bus busy");
    cover property (lock_rd_ack);
    cover property (mem_req_r && mem_we_r && !mem_lock_r);
    cover property (access_err_r);
    cover property (phys_valid_r);
endmodule
bind mtw_walker mtw_walk_chk mtw_walk_chk_inst (.*);

// File: testbench/mtw_mem_model.sv
// table memory on the far side of the walk port
// assumes the bench loads words and sets lat and berr_en directly
`timescale 1ns/1ps
module mtw_mem_model (
    input wire core_clk,
    input wire arst_n,
    input wire mem_req_r,
    input wire mem_we_r,
    input wire mem_lock_r,
    input wire [31:0] mem_addr_r,
    input wire [31:0] mem_wdata_r,
    output reg mem_ack,
    output reg mem_berr,
    output reg [31:0] mem_rdata
);
    reg [31:0] mem [0:1023]; // 4 kbyte word store
    integer lat; // wait states before each ack
    integer cnt; // wait states spent so far
    integer n_wr; // writes seen
    integer n_lk; // locked writes seen
    reg berr_en; // answer with a bus error
    // one op per ack; read data toggle when not valid so stale use shows
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_ack <= 1'b0;
            mem_berr <= 1'b0;
            mem_rdata <= 32'h0;
            cnt <= 0;
        end else if (mem_ack) begin
            mem_ack <= 1'b0;
            mem_berr <= 1'b0;
            mem_rdata <= ~mem_rdata;
            cnt <= 0;
        end else if (mem_req_r && cnt >= lat) begin
            mem_ack <= 1'b1;
            mem_berr <= berr_en;
            mem_rdata <= mem[mem_addr_r[11:2]];
            if (mem_we_r) begin
                mem[mem_addr_r[11:2]] <= mem_wdata_r;
                n_wr <= n_wr + 1;
                n_lk <= n_lk + (mem_lock_r ? 1 : 0);
            end
        end else begin
            mem_rdata <= ~mem_rdata;
            if (mem_req_r) cnt <= cnt + 1;
        end
    end
endmodule

// File: testbench/tb.sv
// self-checking bench for the walk engine
// assumes the table memory model and the bound port checker
`timescale 1ns/1ps
module tb;
    reg core_clk, arst_n, walk_req, walk_write, walk_super, alt_space_move, retry, clk_en;
    reg [31:0] walk_laddr, root_ptr, alt_addr;
    reg [2:0] alt_fc;
    wire mem_req_r, mem_we_r, mem_lock_r, mem_push_inv_r, mem_ack, mem_berr;
    wire [31:0] mem_addr_r, mem_wdata_r, mem_rdata, tc_laddr_r, tc_paddr_r, phys_addr_r;
    wire tc_wr_r, tc_resident_r, tc_wp_r, tc_sup_r, tc_mod_r, walk_done_r, access_err_r;
    wire phys_valid_r;
    wire [1:0] mem_cache_mode_r, transfer_type_r;
    wire [2:0] transfer_modifier_field_r;
    integer n_fail, check_count, k, i;
    reg [7:0] r; // row: write prot used mod | new used, new mod, locked, plain
    // read rows, unprotected write rows, protected write rows
    localparam [95:0] rows = {8'h0a, 8'h1e, 8'h28, 8'h3c, 8'h8d, 8'h9e, 8'had, 8'hbc,
        8'hca, 8'hde, 8'he8, 8'hfc};
    mtw_walker mtw_walker_inst (.clk_en(clk_en), .*);
    mtw_mem_model mtw_mem_model_inst (.*);
    // ---------------------------------------------
    // compare, wait and report tasks
    // ---------------------------------------------
    task chk_word(input [31:0] exp, input [31:0] got, input [8*8-1:0] what);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("MISMATCH %0t %0s exp %h got %h", $time, what, exp, got);
            end
        end
    endtask
    task chk_bit(input exp, input got, input [8*8-1:0] what);
        begin
            chk_word({31'h0, exp}, {31'h0, got}, what);
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", check_count, n_fail);
            if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // bounded wait on a pulse, sampled mid-cycle
    task wait_pulse(input integer which);
        begin
            for (i = 0; i < 300 && (which ? phys_valid_r : walk_done_r) !== 1'b1; i = i + 1)
                @(negedge core_clk);
            if ((which ? phys_valid_r : walk_done_r) !== 1'b1) begin
                n_fail = n_fail + 1;
                $display("MISMATCH %0t no completion", $time);
                close_out;
            end
        end
    endtask
    // one walk request, counters cleared first
    task run_walk(input [31:0] la, input [31:0] rp, input wr, input sup);
        begin
            mtw_mem_model_inst.n_wr = 0;
            mtw_mem_model_inst.n_lk = 0;
            @(posedge core_clk);
            walk_laddr <= la;
            root_ptr <= rp;
            walk_write <= wr;
            walk_super <= sup;
            walk_req <= 1'b1;
            @(posedge core_clk);
            walk_req <= 1'b0;
            wait_pulse(0);
        end
    endtask
    // retry the access; error only for a missing translation
    task do_retry(input exp);
        begin
            @(posedge core_clk);
            retry <= 1'b1;
            @(posedge core_clk);
            retry <= 1'b0;
            @(negedge core_clk);
            chk_bit(exp, access_err_r, "acc_err");
        end
    endtask
    // free running core clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        n_fail = 0;
        check_count = 0;
        {arst_n, walk_req, walk_write, walk_super, alt_space_move, retry, clk_en} = 7'h01;
        {walk_laddr, root_ptr, alt_addr, alt_fc} = 99'h0;
        mtw_mem_model_inst.lat = 0;
        mtw_mem_model_inst.berr_en = 1'b0;
        repeat (20) @(posedge core_clk);
        @(negedge core_clk);
        chk_word(32'h0, {mem_req_r, mem_lock_r, walk_done_r, tc_resident_r}, "rst"); // RESET
        @(posedge core_clk);
        arst_n <= 1'b1;
        // page update rows; odd rows see a slow memory
        for (k = 0; k < 12; k = k + 1) begin
            r = rows[k*8 +: 8];
            mtw_mem_model_inst.lat = (k % 2) * 3;
            mtw_mem_model_inst.mem[10'h000] = 32'h0000020b;
            mtw_mem_model_inst.mem[10'h080] = 32'h0000040a;
            mtw_mem_model_inst.mem[10'h100] = {27'h30, r[4], r[5], r[6], 2'h1};
            run_walk(32'h0, 32'h0, r[7], 1'b1);
            chk_word({27'h30, r[2], r[3], r[6], 2'h1}, mtw_mem_model_inst.mem[10'h100], "page");
            chk_word({31'h0, r[1]}, mtw_mem_model_inst.n_lk, "locked");
            chk_word(r[1] + r[0], mtw_mem_model_inst.n_wr, "writes");
            chk_bit(1'b1, tc_resident_r, "res");
            chk_bit(r[6], tc_wp_r, "wp");
            chk_bit(r[2], tc_mod_r, "mod");
            do_retry(1'b0);
        end
        // protect in an upper table, table used flag clear
        mtw_mem_model_inst.mem[10'h001] = 32'h00000806;
        mtw_mem_model_inst.mem[10'h201] = 32'h00000a0a;
        mtw_mem_model_inst.mem[10'h281] = 32'h00000601;
        run_walk(32'h02041000, 32'h0, 1'b1, 1'b1);
        chk_word(32'h0000080e, mtw_mem_model_inst.mem[10'h001], "table");
        chk_word(32'h00000609, mtw_mem_model_inst.mem[10'h281], "page");
        chk_word(32'h2, mtw_mem_model_inst.n_wr, "writes");
        chk_bit(1'b1, tc_wp_r, "wp");
        // user write to a supervisor page: no modified update
        mtw_mem_model_inst.mem[10'h100] = 32'h00000689;
        run_walk(32'h0, 32'h0, 1'b1, 1'b0);
        chk_word(32'h00000689, mtw_mem_model_inst.mem[10'h100], "sup");
        // absent next table, both invalid codes, junk kept
        for (k = 0; k < 2; k = k + 1) begin
            mtw_mem_model_inst.mem[10'h000] = 32'hdeadbee0 | k;
            run_walk(32'h0, 32'h0, 1'b1, 1'b1);
            chk_word(32'hdeadbee0 | k, mtw_mem_model_inst.mem[10'h000], "inval");
            chk_word(32'h0, mtw_mem_model_inst.n_wr, "writes");
            chk_bit(1'b0, tc_resident_r, "res");
            do_retry(1'b1);
        end
        // bus error ends the walk without translation
        mtw_mem_model_inst.mem[10'h000] = 32'h0000020b;
        mtw_mem_model_inst.berr_en = 1'b1;
        run_walk(32'h0, 32'h0, 1'b0, 1'b1);
        chk_bit(1'b0, tc_resident_r, "berr");
        mtw_mem_model_inst.berr_en = 1'b0;
        // every alternate space code; no instruction cache here to invalidate
        for (k = 0; k < 8; k = k + 1) begin
            @(posedge core_clk);
            alt_fc <= k[2:0];
            alt_addr <= 32'h12345670 + k;
            alt_space_move <= 1'b1;
            @(posedge core_clk);
            alt_space_move <= 1'b0;
            wait_pulse(1);
            chk_word(32'h12345670 + k, phys_addr_r, "phys");
            chk_word((k == 6) ? 5 : ((k == 2) ? 1 : k), transfer_modifier_field_r, "tm");
            chk_word((k[1] == k[0]) ? 2 : 0, transfer_type_r, "tt");
        end
        // clock enable low: a move request must not be taken
        @(posedge core_clk);
        clk_en <= 1'b0;
        alt_addr <= 32'h0;
        alt_space_move <= 1'b1;
        repeat (3) @(posedge core_clk);
        alt_space_move <= 1'b0;
        @(negedge core_clk);
        chk_bit(1'b0, phys_valid_r, "frozen"); // CLKEN
        chk_word(32'h12345677, phys_addr_r, "frozen"); // CLKEN
        @(posedge core_clk);
        clk_en <= 1'b1;
        // second reset in mid-run
        @(posedge core_clk);
        arst_n <= 1'b0;
        @(negedge core_clk);
        chk_word(32'h0, {phys_addr_r[0], tc_wp_r, tc_mod_r, mem_we_r}, "rst2"); // RESET
        close_out;
    end
endmodule
